// [design/rtc_pkg.sv]
/*
 * Package of the receiver input conditioning block: register map,
 * field positions, reset values, setting codes and timing constants.
 * Assumes a single 50 MHz clock and a plain register port.
 */
`default_nettype none
package rtc_pkg;

    // ==================================================
    // Clock and timing
    localparam int unsigned CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned MEAS_WINDOW_MS = 1000;
    localparam int unsigned MEAS_WINDOW_CYC = (CLK_FREQ_HZ / 1000) * MEAS_WINDOW_MS;
    localparam int CNT_W = 26;

    // ==================================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BUTTON = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SETTING = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;

    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PWRINV_BIT = 2;
    localparam logic [1:0] LED_MODE_MAX = 2'h2;
    localparam logic [1:0] LED_MODE_UNTIL_SYNC = 2'h0;
    localparam logic [1:0] LED_MODE_UNSYNCED = 2'h1;
    localparam logic [1:0] LED_MODE_ALWAYS = 2'h2;
    localparam logic [1:0] LED_MODE_RESET = 2'h0;
    localparam logic PWRINV_RESET = 1'b0;

    // Button command fields
    localparam int BTN_PLUS_PULL_BIT = 0;
    localparam int BTN_MINUS_PULL_BIT = 1;
    localparam int BTN_PLUS_INV_BIT = 2;
    localparam int BTN_MINUS_INV_BIT = 3;

    // Setting readback fields
    localparam int SET_PULL_LSB = 0;
    localparam int SET_INV_LSB = 4;

    // Decision of the pull-up while in automatic choice
    localparam logic AUTO_PULLUP_EN = 1'b1;

    // ==================================================
    // Types
    typedef enum logic [2:0] {
        RTC_SEL_AUTO = 3'b001,
        RTC_SEL_ON = 3'b010,
        RTC_SEL_OFF = 3'b100
    } rtc_sel_t;

    typedef struct packed {
        logic rxData;
        logic ledOn;
        logic pullUpEn;
        logic effInvert;
        logic autoInvert;
        logic everSynced;
    } rtc_status_t;

    typedef struct packed {
        logic [1:0] ledMode;
        logic powerInvert;
        rtc_sel_t pullSel;
        rtc_sel_t invSel;
        logic everSynced;
        logic autoInvert;
        logic [CNT_W-1:0] winCnt;
        logic [CNT_W-1:0] highCnt;
        rtc_status_t status;
        logic rxPower;
        logic [DATA_W-1:0] rdata;
    } rtc_state_t;

endpackage : rtc_pkg

`default_nettype wire

// [design/rtc_input_cond.sv]
/*
 * Input conditioning and indication for a long-wave time-signal
 * receiver: indicator LED gating, input pull-up choice, input polarity
 * choice with automatic detection, and receiver power pin polarity.
 * Assumes all inputs synchronous to clk and a master that issues
 * one-cycle strobes and takes read data in the following cycle.
 */
// Summary of operation
// - LED mode register holds values zero to two only.
// - Mode zero: LED mirrors pulses only until first synchronisation.
// - Mode one: LED mirrors pulses while clock is not synchronised.
// - Mode two: LED always mirrors pulses, synchronised flag ignored.
// - LED mirrors only during an active reception attempt.
// - Pull-up choice resets to automatic; device decides the pull-up.
// - Forced on enables the pull-up; forced off disables it.
// - Plus selects automatic; minus forces and toggles on and off.
// - Inversion choice resets to automatic; device decides polarity.
// - Forced on inverts the input; forced off passes it unchanged.
// - Power pin inverted: low powers receiver, high switches off.
// - Power pin normal: high powers receiver, low switches off.
`timescale 1ns/1ps
`default_nettype none

module rtc_input_cond
    import rtc_pkg::*;
#(
    parameter int unsigned WINDOW_CYC = MEAS_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire logic rxIn,
    input wire logic receiving,
    input wire logic synced,
    input wire logic powerReq,
    output logic rxData,
    output logic ledOut,
    output logic pullUpEn,
    output logic rxPowerOut,
    output rtc_status_t status
);

    // ==================================================
    // Helpers
    function automatic rtc_sel_t selPlus(input rtc_sel_t cur);
        selPlus = RTC_SEL_AUTO;
    endfunction

    function automatic rtc_sel_t selMinus(input rtc_sel_t cur);
        selMinus = (cur == RTC_SEL_ON) ? RTC_SEL_OFF : RTC_SEL_ON;
    endfunction

    function automatic logic selApply(input rtc_sel_t sel, input logic autoVal);
        unique case (sel)
            RTC_SEL_AUTO: selApply = autoVal;
            RTC_SEL_ON: selApply = 1'b1;
            RTC_SEL_OFF: selApply = 1'b0;
            default: selApply = autoVal;
        endcase
    endfunction

    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYC - 1);
    localparam logic [CNT_W-1:0] WIN_HALF = CNT_W'(WINDOW_CYC / 2);

    // ==================================================
    // State
    rtc_state_t state_reg;
    rtc_state_t state_next;

    logic effInv;
    logic pullEff;
    logic condIn;
    logic ledGate;
    logic winEnd;
    logic writeCtrl;
    logic writeBtn;

    always_comb begin
        effInv = selApply(state_reg.invSel, state_reg.autoInvert);
        pullEff = selApply(state_reg.pullSel, AUTO_PULLUP_EN);
        condIn = rxIn ^ effInv;
        unique case (state_reg.ledMode)
            LED_MODE_UNTIL_SYNC: ledGate = !state_reg.everSynced;
            LED_MODE_UNSYNCED: ledGate = !synced;
            LED_MODE_ALWAYS: ledGate = 1'b1;
            default: ledGate = 1'b0;
        endcase
        winEnd = (state_reg.winCnt == WIN_LAST);
        writeCtrl = regWr && (regAddr == ADDR_CTRL);
        writeBtn = regWr && (regAddr == ADDR_BUTTON);
    end

    always_comb begin
        state_next = state_reg;

        // Control register
        if (writeCtrl) begin
            if (regWdata[CTRL_MODE_LSB +: 2] <= LED_MODE_MAX) begin
                state_next.ledMode = regWdata[CTRL_MODE_LSB +: 2];
            end
            state_next.powerInvert = regWdata[CTRL_PWRINV_BIT];
        end

        // Button commands
        if (writeBtn) begin
            if (regWdata[BTN_PLUS_PULL_BIT]) begin
                state_next.pullSel = selPlus(state_reg.pullSel);
            end else if (regWdata[BTN_MINUS_PULL_BIT]) begin
                state_next.pullSel = selMinus(state_reg.pullSel);
            end
            if (regWdata[BTN_PLUS_INV_BIT]) begin
                state_next.invSel = selPlus(state_reg.invSel);
            end else if (regWdata[BTN_MINUS_INV_BIT]) begin
                state_next.invSel = selMinus(state_reg.invSel);
            end
        end

        // First synchronisation is remembered until reset
        if (synced) begin
            state_next.everSynced = 1'b1;
        end

        // Polarity detection over one-second windows of reception
        if (receiving) begin
            if (winEnd) begin
                state_next.winCnt = '0;
                state_next.highCnt = '0;
                state_next.autoInvert = (state_reg.highCnt > WIN_HALF);
            end else begin
                state_next.winCnt = state_reg.winCnt + CNT_W'(1);
                if (rxIn) begin
                    state_next.highCnt = state_reg.highCnt + CNT_W'(1);
                end
            end
        end else begin
            state_next.winCnt = '0;
            state_next.highCnt = '0;
        end

        // Receiver power pin
        state_next.rxPower = powerReq ^ state_reg.powerInvert;

        // Conditioned outputs
        state_next.status.rxData = condIn;
        state_next.status.ledOn = receiving && ledGate && condIn;
        state_next.status.pullUpEn = pullEff;
        state_next.status.effInvert = effInv;
        state_next.status.autoInvert = state_reg.autoInvert;
        state_next.status.everSynced = state_reg.everSynced;

        // Read data, valid only in the cycle after the strobe
        state_next.rdata = '0;
        if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    state_next.rdata[CTRL_MODE_LSB +: 2] = state_reg.ledMode;
                    state_next.rdata[CTRL_PWRINV_BIT] = state_reg.powerInvert;
                end
                ADDR_SETTING: begin
                    state_next.rdata[SET_PULL_LSB +: 3] = state_reg.pullSel;
                    state_next.rdata[SET_INV_LSB +: 3] = state_reg.invSel;
                end
                ADDR_STATUS: begin
                    state_next.rdata[$bits(rtc_status_t)-1:0] = state_reg.status;
                end
                default: state_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.ledMode <= LED_MODE_RESET;
            state_reg.powerInvert <= PWRINV_RESET;
            state_reg.pullSel <= RTC_SEL_AUTO;
            state_reg.invSel <= RTC_SEL_AUTO;
            state_reg.everSynced <= 1'b0;
            state_reg.autoInvert <= 1'b0;
            state_reg.winCnt <= '0;
            state_reg.highCnt <= '0;
            state_reg.status <= '0;
            state_reg.rxPower <= PWRINV_RESET;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================
    // Outputs
    assign regRdata = state_reg.rdata;
    assign rxData = state_reg.status.rxData;
    assign ledOut = state_reg.status.ledOn;
    assign pullUpEn = state_reg.status.pullUpEn;
    assign rxPowerOut = state_reg.rxPower;
    assign status = state_reg.status;

endmodule // rtc_input_cond

`default_nettype wire

// [tb/rtc_input_cond_sva.sv]
/* Port checker of the receiver input conditioning block.
   Assumes it is bound to the block top by port name. */
`timescale 1ns/1ps
`default_nettype none
module rtc_input_cond_sva
    import rtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic rxIn,
    input wire logic receiving,
    input wire logic synced,
    input wire logic powerReq,
    input wire logic rxData,
    input wire logic ledOut,
    input wire logic pullUpEn,
    input wire logic rxPowerOut,
    input wire rtc_status_t status
);
    // ==================================================
    // Sequences
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [ADDR_W-1:0] a);
        regRd && regAddr == a ##1 1'b1;
    endsequence

    // ==================================================
    // Properties
    property p_mode; s_rd(ADDR_CTRL) |-> regRdata[1:0] != 2'h3; endproperty
    a_mode: assert property (p_mode) else $error("mode out of range");
    property p_sel; s_rd(ADDR_SETTING) |-> $onehot(regRdata[2:0]) && $onehot(regRdata[6:4]);
    endproperty
    a_sel: assert property (p_sel) else $error("setting code bad");
    property p_sync; synced |-> ##2 status.everSynced; endproperty
    a_sync: assert property (p_sync) else $error("sync not recorded");
    property p_stick; status.everSynced |=> status.everSynced; endproperty
    a_stick: assert property (p_stick) else $error("sync flag dropped");
    property p_recv; !receiving |=> !ledOut; endproperty
    a_recv: assert property (p_recv) else $error("led outside reception");
    property p_led; ledOut |-> rxData; endproperty
    a_led: assert property (p_led) else $error("led without pulse");
    property p_pull; s_rd(ADDR_SETTING) |-> status.pullUpEn == (regRdata[2:0] != 3'h4);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up mismatch");
    property p_pol; $past(rst_n) && $stable(status.effInvert)
        |-> rxData == ($past(rxIn) ^ status.effInvert); endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong");
    property p_pwr; $changed(powerReq) |=> $changed(rxPowerOut); endproperty
    a_pwr: assert property (p_pwr) else $error("power pin stuck");
    property p_auto; $changed(status.autoInvert) |-> $past(receiving); endproperty
    a_auto: assert property (p_auto) else $error("auto change idle");
endmodule // rtc_input_cond_sva
`default_nettype wire

// [tb/rtc_receiver_model.sv]
/* Behavioural time-signal receiver: one pulse a period.
   Assumes the bench clock; unpowered line floats to the pull-up or toggles. */
`timescale 1ns/1ps
`default_nettype none
module rtc_receiver_model #(
    parameter int PERIOD = 20,
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic powerOn,
    input wire logic pullUp,
    input wire logic activeLow,
    output logic rxOut
);
    int phase = 0;
    logic idle = 1'b0;
    initial rxOut = 1'b0;
    always @(posedge clk) begin
        phase <= (phase + 1) % PERIOD;
        idle <= !idle;
        if (powerOn) begin
            rxOut <= (phase < WIDTH) ^ activeLow;
        end else begin
            rxOut <= pullUp ? 1'b1 : idle;
        end
    end
endmodule // rtc_receiver_model
`default_nettype wire

// [tb/rtc_input_cond_bench.sv]
/* Bench of the input conditioning block: register tasks and tests.
   Assumes the receiver model and the port checker in tb. */
`timescale 1ns/1ps
`default_nettype none
module rtc_input_cond_bench
    import rtc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0, regRdata, rdVal;
    logic rxIn, rxData, ledOut, pullUpEn, rxPowerOut;
    logic receiving = 1'b0, synced = 1'b0, powerReq = 1'b1, activeLow = 1'b0, pinv = 1'b0;
    logic [3:0] btn [7] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h8, 4'h8, 4'h4};
    logic [7:0] setv [7] = '{8'h12, 8'h14, 8'h12, 8'h11, 8'h21, 8'h41, 8'h11};
    rtc_status_t status;
    int failures = 0, check_count = 0, n;
    initial forever #10 clk = ~clk;
    rtc_input_cond #(.WINDOW_CYC(20)) u_rtc_input_cond(.clk, .rst_n, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .rxIn, .receiving, .synced, .powerReq, .rxData, .ledOut,
        .pullUpEn, .rxPowerOut, .status);
    rtc_receiver_model u_rtc_receiver_model(.clk, .powerOn(rxPowerOut != pinv),
        .pullUp(pullUpEn), .activeLow, .rxOut(rxIn));

    // ==================================================
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdVal = regRdata;
    endtask
    task led_cnt;
        n = 0;
        repeat (3) @(posedge clk);
        repeat (40) @(negedge clk) if (ledOut === 1'b1) n++;
    endtask
    task pol(input logic inv);
        logic r;
        repeat (12) begin
            @(negedge clk);
            r = rxIn;
            @(negedge clk);
            check(rxData, r ^ inv);
        end
    endtask
    task end_of_test;
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL);
        check(rdVal, 32'h0);
        check(pullUpEn, 1'b1);
        wr(ADDR_CTRL, 32'h3);
        rd(ADDR_CTRL);
        check(rdVal, 32'h0);
        receiving <= 1'b1;
        led_cnt();
        check(n > 0, 1'b1);
        synced <= 1'b1;
        repeat (2) @(posedge clk);
        synced <= 1'b0;
        led_cnt();
        check(n > 0, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        led_cnt();
        check(n > 0, 1'b1);
        synced <= 1'b1;
        led_cnt();
        check(n > 0, 1'b0);
        wr(ADDR_CTRL, 32'h2);
        led_cnt();
        check(n > 0, 1'b1);
        receiving <= 1'b0;
        led_cnt();
        check(n > 0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            powerReq <= i[0];
            repeat (3) @(posedge clk);
            wr(ADDR_CTRL, {29'h0, i[1], 2'h2});
            pinv <= i[1];
            repeat (2) @(posedge clk);
            #1 check(rxPowerOut, i[0] ^ i[1]);
        end
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_BUTTON, {28'h0, btn[i]});
            rd(ADDR_SETTING);
            check(rdVal, {24'h0, setv[i]});
            check(pullUpEn, setv[i][3:0] != 4'h4);
            pol(setv[i][7:4] == 4'h2);
        end
        receiving <= 1'b1;
        activeLow <= 1'b1;
        repeat (70) @(posedge clk);
        rd(ADDR_STATUS);
        check(rdVal[2:1], 2'h3);
        pol(1'b1);
        activeLow <= 1'b0;
        repeat (70) @(posedge clk);
        rd(ADDR_STATUS);
        check(rdVal[2:1], 2'h0);
        end_of_test();
    end
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
endmodule // rtc_input_cond_bench
bind rtc_input_cond rtc_input_cond_sva u_rtc_input_cond_sva(.clk, .rst_n, .regAddr, .regRd,
    .regRdata, .rxIn, .receiving, .synced, .powerReq, .rxData, .ledOut, .pullUpEn,
    .rxPowerOut, .status);
`default_nettype wire
